// ===== rtl/sbbp_consts.vh
// constants for the six-bit bidirectional port: offsets, fields, reset values
`ifndef SBBP_CONSTS_VH
`define SBBP_CONSTS_VH

// ==========================================================================
// register byte offsets (word aligned)
`define SBBP_OFF_PIN_DATA   4'h0
`define SBBP_OFF_DIRECTION  4'h4
`define SBBP_OFF_ANALOG     4'h8
`define SBBP_OFF_CONFIG     4'hC

// ==========================================================================
// field positions
`define SBBP_PIN_THREE      3
`define SBBP_CFG_MCLR_BIT   0
`define SBBP_CFG_XT_BIT     1
`define SBBP_CFG_HS_BIT     2
`define SBBP_CFG_LP_BIT     3
`define SBBP_CFG_WIDTH      4

// ==========================================================================
// reset values
`define SBBP_DIR_RESET      6'h3F
`define SBBP_ANALOG_RESET   6'h3F
`define SBBP_CFG_RESET      4'h0
`define SBBP_LATCH_RESET    6'h00

// ==========================================================================
// axi answers
`define SBBP_RESP_OKAY      2'h0
`define SBBP_RESP_SLVERR    2'h2

`endif

// ===== rtl/sbbp_pin_cell.v
// one pin cell: direction, driver enable, and read-side masking
`timescale 1ns/1ns
`default_nettype none

module sbbp_pin_cell
(
  // configuration
  input  wire dir_bit,
  input  wire latch_bit,
  input  wire analog_bit,
  input  wire periph_en,
  input  wire periph_out,
  input  wire periph_oe,
  input  wire force_zero,
  input  wire input_only,
  // pad
  input  wire pad_i,
  output wire pad_o,
  output wire pad_oe,
  // read side
  output wire read_bit
);

  // ========================================================================
  // driver: peripheral wins except on input-only pins, else direction bit controls driver even on analog
  assign pad_o    = periph_en ? periph_out : latch_bit;
  assign pad_oe   = ~input_only & (periph_en ? periph_oe : ~dir_bit);
  // analog or forced pins read zero
  assign read_bit = pad_i & ~analog_bit & ~force_zero;

endmodule
`default_nettype wire

// ===== rtl/sbbp_port.v
// six-bit bidirectional port with axi4-lite register access
`timescale 1ns/1ns
`default_nettype none
`include "sbbp_consts.vh"

module sbbp_port
#(
  parameter WIDTH = 6
)
(
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // axi4-lite write address
  input  wire [3:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // peripheral override per pin
  input  wire [WIDTH-1:0] periph_en,
  input  wire [WIDTH-1:0] periph_out,
  input  wire [WIDTH-1:0] periph_oe,
  // pads
  input  wire [WIDTH-1:0] pad_i,
  output wire [WIDTH-1:0] pad_o,
  output wire [WIDTH-1:0] pad_oe
);

  // ========================================================================
  // state
  reg  [WIDTH-1:0] latch_q;
  reg  [WIDTH-1:0] dir_q;
  reg  [WIDTH-1:0] analog_q;
  reg  [`SBBP_CFG_WIDTH-1:0] cfg_q;
  reg  [3:0]       awaddr_q;
  reg              aw_held_q;
  reg  [31:0]      wdata_q;
  reg  [3:0]       wstrb_q;
  reg              w_held_q;
  wire [WIDTH-1:0] pin_read;
  wire [WIDTH-1:0] dir_read;
  wire [WIDTH-1:0] force_zero;
  wire [WIDTH-1:0] input_only;
  wire             osc_crystal;
  wire             do_write;
  wire [7:0]       wr_byte;

  // ========================================================================
  // per-pin cells
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_pin
      assign force_zero[gi] = (gi == `SBBP_PIN_THREE) & cfg_q[`SBBP_CFG_MCLR_BIT];
      assign input_only[gi] = (gi == `SBBP_PIN_THREE);
      sbbp_pin_cell u_cell
      (
        .dir_bit    (dir_q[gi]),
        .latch_bit  (latch_q[gi]),
        .analog_bit (analog_q[gi]),
        .periph_en  (periph_en[gi]),
        .periph_out (periph_out[gi]),
        .periph_oe  (periph_oe[gi]),
        .force_zero (force_zero[gi]),
        .input_only (input_only[gi]),
        .pad_i      (pad_i[gi]),
        .pad_o      (pad_o[gi]),
        .pad_oe     (pad_oe[gi]),
        .read_bit   (pin_read[gi])
      );
    end
  endgenerate

  // ========================================================================
  // direction readback with forced ones
  assign osc_crystal = cfg_q[`SBBP_CFG_XT_BIT] | cfg_q[`SBBP_CFG_HS_BIT]
                     | cfg_q[`SBBP_CFG_LP_BIT];
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_dir
      assign dir_read[gi] = dir_q[gi] | (gi == `SBBP_PIN_THREE)
                          | (osc_crystal & (gi == 4 || gi == 5));
    end
  endgenerate

  // ========================================================================
  // write channel capture: address and data taken in either order
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
  assign do_write      = aw_held_q & w_held_q;
  assign wr_byte       = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

  always @(posedge clk)
  begin
    if (rst)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (do_write)
        w_held_q <= 1'b0;
    end
  end

  // ========================================================================
  // register update and write response
  always @(posedge clk)
  begin
    if (rst)
    begin
      dir_q        <= `SBBP_DIR_RESET;
      analog_q     <= `SBBP_ANALOG_RESET;
      cfg_q        <= `SBBP_CFG_RESET;
      latch_q      <= `SBBP_LATCH_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SBBP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SBBP_RESP_OKAY;
        case (awaddr_q)
          `SBBP_OFF_PIN_DATA:
            if (wstrb_q[0])
              latch_q <= wr_byte[WIDTH-1:0];
          `SBBP_OFF_DIRECTION:
            if (wstrb_q[0])
              dir_q <= wr_byte[WIDTH-1:0];
          `SBBP_OFF_ANALOG:
            if (wstrb_q[0])
              analog_q <= wr_byte[WIDTH-1:0];
          `SBBP_OFF_CONFIG:
            if (wstrb_q[0])
              cfg_q <= wr_byte[`SBBP_CFG_WIDTH-1:0];
          default:
            s_axi_bresp <= `SBBP_RESP_SLVERR;
        endcase
      end
    end
  end

  // ========================================================================
  // read channel: one-cycle registered answer; pin data is pad_i masked by the analog and forced-zero bits
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SBBP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SBBP_RESP_OKAY;
        case (s_axi_araddr)
          `SBBP_OFF_PIN_DATA:
            s_axi_rdata <= {{(32-WIDTH){1'b0}}, pin_read};
          `SBBP_OFF_DIRECTION:
            s_axi_rdata <= {{(32-WIDTH){1'b0}}, dir_read};
          `SBBP_OFF_ANALOG:
            s_axi_rdata <= {{(32-WIDTH){1'b0}}, analog_q};
          `SBBP_OFF_CONFIG:
            s_axi_rdata <= {{(32-`SBBP_CFG_WIDTH){1'b0}}, cfg_q};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SBBP_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== sim/sbbp_pins.sv
// board side of the port: pull-ups and an optional external driver
`timescale 1ns/1ns
`default_nettype none
module sbbp_pins
(
  // port side and board drive
  input  wire logic [5:0] pad_o,
  input  wire logic [5:0] pad_oe,
  input  wire logic [5:0] ext,
  input  wire logic       ext_en,
  output logic      [5:0] pad_i
);
  // a driven pin shows the port, a released one the board or its pull-up
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & (ext_en ? ext : 6'h3F));
endmodule
`default_nettype wire

// ===== sim/sbbp_port_sva.sv
// assertions on the ports of the six-bit port
`timescale 1ns/1ns
`default_nettype none
module sbbp_port_sva
(
  // clock, reset and bus handshakes
  input wire logic        clk, rst, s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  // pins and peripheral override
  input wire logic [5:0]  periph_en, periph_out, periph_oe, pad_o, pad_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_pin3_undriven: assert property (!pad_oe[3])
    else $error("pin three driven");
  a_periph_owns_out: assert property (((pad_o ^ periph_out) & periph_en) == 6'h00)
    else $error("peripheral output lost");
  a_periph_owns_oe: assert property (((pad_oe ^ periph_oe) & periph_en & 6'h37) == 6'h00)
    else $error("peripheral enable lost");
  a_reset_all_inputs: assert property (disable iff (1'b0) rst |=> (pad_oe & ~periph_en) == 6'h00)
    else $error("pin driven after reset");
  a_high_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("upper read bits set");
  a_dir_pin3_one: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) == 4'h4 |-> s_axi_rdata[3])
    else $error("pin three direction reads zero");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
endmodule
bind sbbp_port sbbp_port_sva u_sva (.*);
`default_nettype wire

// ===== sim/six_bit_bidir_port_bench.sv
// bench for the six-bit port: register calls over axi4-lite
`timescale 1ns/1ns
`default_nettype none
module six_bit_bidir_port_bench;
  logic        clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, ext_en = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [5:0]  periph_en = 0, periph_out = 0, periph_oe = 0, ext = 0, pad_i, pad_o, pad_oe;
  integer      n_fail = 0, checks_done = 0, k;
  sbbp_port dut (.*);
  sbbp_pins board (.pad_o, .pad_oe, .ext, .ext_en, .pad_i);
  // clock
  always #5 clk = ~clk;
  task final_report;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one write (w=1) or read, holding each channel until its handshake
  task bus(input bit w, input [3:0] a, input [31:0] d);
    integer i;
    logic pa, pw, pr;
    @(posedge clk);
    if (w)
    begin
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    end
    else
    begin
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    end
    for (i = 0; i < 50; i++)
    begin
      @(negedge clk);
      pa = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      pw = s_axi_wvalid && s_axi_wready;
      pr = w ? s_axi_bvalid : s_axi_rvalid;
      rq = s_axi_rdata;
      rr = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (pa) begin s_axi_awvalid <= 0; s_axi_arvalid <= 0; end
      if (pw) s_axi_wvalid <= 0;
      if (pr) begin s_axi_bready <= 0; s_axi_rready <= 0; break; end
    end
    if (i == 50) begin n_fail++; final_report; end
  endtask
  // compare the last answer: response code, and data when d is set
  task ck(input [1:0] er, input [31:0] e, input bit d);
    checks_done++;
    if (rr !== er || (d && rq !== e))
    begin
      n_fail++; $display("BAD %0t resp %h data %h exp %h", $time, rr, rq, e);
    end
  endtask
  // compare pin enables and driven levels
  task pin(input [5:0] eoe, input [5:0] eo);
    @(negedge clk);
    checks_done++;
    if (pad_oe !== eoe || (pad_o & eoe) !== eo)
    begin
      n_fail++; $display("BAD %0t pins oe %h out %h", $time, pad_oe, pad_o);
    end
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    bus(0, 4'h4, 0); ck(0, 32'h3F, 1);
    bus(0, 4'h8, 0); ck(0, 32'h3F, 1);
    bus(0, 4'h0, 0); ck(0, 32'h00, 1);
    $display("test 1 done");
    bus(1, 4'h8, 0); ck(0, 0, 0);
    bus(1, 4'h4, 0); ck(0, 0, 0);
    bus(0, 4'h4, 0); ck(0, 32'h08, 1);
    bus(1, 4'h0, 32'h15); ck(0, 0, 0);
    bus(0, 4'h0, 0); ck(0, 32'h1D, 1);
    pin(6'h37, 6'h15);
    @(posedge clk);
    periph_en <= 6'h01;
    pin(6'h36, 6'h14);
    @(posedge clk);
    periph_en <= 6'h00;
    $display("test 2 done");
    bus(1, 4'h4, 32'h3F);
    ext <= 6'h2B; ext_en <= 1;
    bus(0, 4'h0, 0); ck(0, 32'h2B, 1);
    bus(1, 4'hC, 32'h1); bus(0, 4'h0, 0); ck(0, 32'h23, 1);
    bus(1, 4'h8, 32'h1); bus(0, 4'h0, 0); ck(0, 32'h22, 1);
    bus(1, 4'h4, 0); pin(6'h37, 6'h15);
    $display("test 3 done");
    for (k = 1; k < 4; k++)
    begin
      bus(1, 4'hC, 32'h1 << k); bus(0, 4'h4, 0); ck(0, 32'h38, 1);
    end
    bus(0, 4'h6, 0); ck(2, 0, 1);
    $display("test 4 done");
    final_report;
  end
endmodule
`default_nettype wire
